// ### core/pwic_pkg.sv
package pwic_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int VPE_COUNT = 2;
	localparam int VPE_W     = 1;

	// ----------------------------------------------------------------
	// register numbers and selects
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_NUM_WALK  = 5'h05; // base, position, widths
	localparam logic [4:0] REG_NUM_CTRL  = 5'h06; // walk_control
	localparam logic [2:0] SEL_BASE      = 3'h5;
	localparam logic [2:0] SEL_POSITION  = 3'h6;
	localparam logic [2:0] SEL_WIDTHS    = 3'h7;
	localparam logic [2:0] SEL_CONTROL   = 3'h6;

	// slot of each register inside one per-element configuration word
	localparam logic [1:0] SLOT_BASE     = 2'h0;
	localparam logic [1:0] SLOT_POSITION = 2'h1;
	localparam logic [1:0] SLOT_WIDTHS   = 2'h2;
	localparam logic [1:0] SLOT_CONTROL  = 2'h3;

	// ----------------------------------------------------------------
	// reset values and limits
	// ----------------------------------------------------------------
	localparam logic [5:0]  POS_RST_NEWEST   = 6'h0c;
	localparam logic [5:0]  POS_RST_EARLIER  = 6'h00;
	localparam logic [5:0]  POS_MIN_NEWEST   = 6'h0c;
	localparam logic [5:0]  ENTRY_SHIFT_RST  = 6'h02;
	localparam logic [5:0]  ENTRY_SHIFT_MIN  = 6'h02;
	localparam logic [5:0]  ENTRY_SHIFT_MAX  = 6'h08;
	localparam logic [5:0]  ENTRY_SHIFT_BIAS = 6'h02;
	localparam logic [5:0]  EXTRA_SCALE_MAX  = 6'h01;
	localparam logic [5:0]  PTR_SCALE        = 6'h02; // 32-bit pointers
	localparam logic [31:0] BASE_RST         = 32'h0;
	localparam logic [31:0] WIDTHS_RST       = 32'h0;
	localparam logic [31:0] CONTROL_RST      = 32'h0;
	localparam logic [1:0]  LVL_LEAF         = 2'h3;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] zero;
		logic [5:0] global_dir_position;
		logic [5:0] upper_dir_position;
		logic [5:0] middle_dir_position;
		logic [5:0] leaf_table_position;
		logic [5:0] entry_shift;
	} pwic_position_t;

	typedef struct packed {
		logic       zero;
		logic       pointer_size;
		logic [5:0] global_dir_width;
		logic [5:0] upper_dir_width;
		logic [5:0] middle_dir_width;
		logic [5:0] leaf_table_width;
		logic [5:0] entry_extra_scale;
	} pwic_widths_t;

	typedef struct packed {
		logic        walk_enable;
		logic [30:0] zero;
	} pwic_control_t;

	typedef struct packed {
		pwic_control_t  control;
		pwic_widths_t   widths;
		pwic_position_t position;
		logic [31:0]    base;
	} pwic_cfg_t;

	typedef struct packed {
		logic        read_inhibit;
		logic        execute_inhibit;
		logic [29:0] entry_low;
		logic [5:0]  page_shift;
	} pwic_tlb_t;

endpackage

// ### core/pwic_vpe_regs.sv
`timescale 1ns/100ps
module pwic_vpe_regs #(
	parameter pwic_pkg::pwic_cfg_t RST_WORD = '0
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      wr_en,
	input  wire logic [pwic_pkg::VPE_W-1:0] wr_vpe,
	input  wire logic [1:0]                wr_slot,
	input  wire logic [31:0]               wr_data,
	input  wire logic [pwic_pkg::VPE_W-1:0] rd_a_vpe,
	output pwic_pkg::pwic_cfg_t            rd_a_data,
	input  wire logic [pwic_pkg::VPE_W-1:0] rd_b_vpe,
	output pwic_pkg::pwic_cfg_t            rd_b_data
);

	// ----------------------------------------------------------------
	// one configuration word per processing element
	// ----------------------------------------------------------------
	logic [127:0] word_q [pwic_pkg::VPE_COUNT];

	genvar gv;
	generate
		for (gv = 0; gv < pwic_pkg::VPE_COUNT; gv++) begin : g_vpe
			wire logic hit = wr_en && (wr_vpe == (pwic_pkg::VPE_W)'(gv));
			// a write touches one 32-bit slot only, the others keep their value
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					word_q[gv] <= RST_WORD;
				end else if (ce && hit) begin
					word_q[gv][wr_slot*32 +: 32] <= wr_data;
				end
			end
		end
	endgenerate

	// registered read ports, so the walker and the register read never race
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_a_data <= RST_WORD;
			rd_b_data <= RST_WORD;
		end else if (ce) begin
			rd_a_data <= word_q[rd_a_vpe];
			rd_b_data <= word_q[rd_b_vpe];
		end
	end

endmodule

// ### core/pwic_walker.sv
// Operation
// RULE1 - position register exists only when walker present
// RULE2 - read fault aborts walk, raises refill exception
// RULE3 - five 6-bit position fields at fixed bits
// RULE4 - bits 31:30 read zero
// RULE5 - position gives index lsb, width gives count
// RULE6 - newest release drops write with position below 12
// RULE7 - positions reset 0 earlier, 12 newest
// RULE8 - leaf page size rounded down to power four
// RULE9 - entry shift resets to 2, drives shift
// RULE10 - shift entry by shift-2, rotate two bits up
// RULE11 - software avoids entry shift 0 or 1
// RULE12 - newest release ignores unsupported entry shift writes
// RULE13 - unsupported shift write leaves field readable unchanged
// RULE14 - directory index scaled by two-bit left shift
// RULE15 - leaf index scaled further by extra scale
// RULE16 - walk starts from base register address
// RULE17 - up to four directories plus leaf table; code walks three (global, upper, middle) plus leaf
// RULE18 - separate register copies per processing element
// RULE19 - zero directory width means no read
// RULE20 - base register 32-bit, resets to zero
// RULE21 - aborted walk writes nothing, keeps faulting address
`timescale 1ns/100ps
module pwic_walker #(
	parameter bit NEWEST_RELEASE = 1'b1
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic                      ce,
	input  wire logic                      walker_present_bit,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [4:0]                reg_num,
	input  wire logic [2:0]                reg_sel,
	input  wire logic [pwic_pkg::VPE_W-1:0] reg_vpe,
	input  wire logic [31:0]               reg_wdata,
	output logic [31:0]                    reg_rdata,
	output logic                           reg_rvalid,
	input  wire logic                      walk_req,
	input  wire logic [pwic_pkg::VPE_W-1:0] walk_vpe,
	input  wire logic [31:0]               walk_addr,
	output logic                           walk_busy,
	output logic                           mem_req,
	output logic [31:0]                    mem_addr,
	input  wire logic                      mem_rvalid,
	input  wire logic                      mem_fault,
	input  wire logic [31:0]               mem_rdata,
	output logic                           tlb_we,
	output pwic_pkg::pwic_tlb_t            tlb_entry,
	output logic                           refill_exc,
	output logic [31:0]                    exc_addr
);

	typedef enum logic [2:0] {
		PWIC_IDLE,
		PWIC_CFG,
		PWIC_LEVEL,
		PWIC_WAIT
	} pwic_state_t;

	// ----------------------------------------------------------------
	// reset word of one processing element
	// ----------------------------------------------------------------
	localparam logic [5:0] POS_RST = NEWEST_RELEASE ? pwic_pkg::POS_RST_NEWEST
	                                                : pwic_pkg::POS_RST_EARLIER; // RULE7
	localparam pwic_pkg::pwic_cfg_t CFG_RST = '{
		control:  pwic_pkg::CONTROL_RST,
		widths:   pwic_pkg::WIDTHS_RST,
		position: '{zero: 2'h0,
		            global_dir_position: POS_RST,
		            upper_dir_position:  POS_RST,
		            middle_dir_position: POS_RST,
		            leaf_table_position: POS_RST,
		            entry_shift: pwic_pkg::ENTRY_SHIFT_RST},
		base:     pwic_pkg::BASE_RST
	};

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	wire logic num_walk = (reg_num == pwic_pkg::REG_NUM_WALK);
	wire logic num_ctrl = (reg_num == pwic_pkg::REG_NUM_CTRL);
	wire logic hit_base = num_walk && (reg_sel == pwic_pkg::SEL_BASE);
	wire logic hit_pos  = num_walk && (reg_sel == pwic_pkg::SEL_POSITION);
	wire logic hit_wid  = num_walk && (reg_sel == pwic_pkg::SEL_WIDTHS);
	wire logic hit_ctl  = num_ctrl && (reg_sel == pwic_pkg::SEL_CONTROL);
	// every walker register vanishes when the walker is not fitted
	wire logic hit_any  = walker_present_bit && (hit_base || hit_pos || hit_wid || hit_ctl); // RULE1

	wire logic [1:0] hit_slot = hit_base ? pwic_pkg::SLOT_BASE :
	                            hit_pos  ? pwic_pkg::SLOT_POSITION :
	                            hit_wid  ? pwic_pkg::SLOT_WIDTHS : pwic_pkg::SLOT_CONTROL;

	// ----------------------------------------------------------------
	// write filtering of the position register
	// ----------------------------------------------------------------
	pwic_pkg::pwic_position_t pos_in;
	pwic_pkg::pwic_position_t pos_wr;
	assign pos_in = pwic_pkg::pwic_position_t'(reg_wdata);

	wire logic pos_low = (pos_in.global_dir_position < pwic_pkg::POS_MIN_NEWEST)
	                  || (pos_in.upper_dir_position  < pwic_pkg::POS_MIN_NEWEST)
	                  || (pos_in.middle_dir_position < pwic_pkg::POS_MIN_NEWEST)
	                  || (pos_in.leaf_table_position < pwic_pkg::POS_MIN_NEWEST); // RULE6
	// shifts outside the fitted range are not available here
	wire logic shift_bad = (pos_in.entry_shift < pwic_pkg::ENTRY_SHIFT_MIN)
	                    || (pos_in.entry_shift > pwic_pkg::ENTRY_SHIFT_MAX); // RULE12
	// earlier releases store whatever is written; shift 0 and 1 are the user's risk
	wire logic pos_ok  = !NEWEST_RELEASE || (!pos_low && !shift_bad); // RULE6 RULE12 RULE13 RULE11

	// top two bits are never stored, so they always read back as zero
	always_comb begin
		pos_wr      = pos_in; // RULE3
		pos_wr.zero = 2'h0;   // RULE4
	end

	// ----------------------------------------------------------------
	// write filtering of the widths and control registers
	// ----------------------------------------------------------------
	pwic_pkg::pwic_widths_t  wid_in;
	pwic_pkg::pwic_widths_t  wid_wr;
	pwic_pkg::pwic_control_t ctl_wr;
	assign wid_in = pwic_pkg::pwic_widths_t'(reg_wdata);

	// a zero leaf width drops the whole write in the newest release
	wire logic wid_ok = !NEWEST_RELEASE || (wid_in.leaf_table_width != 6'h00);

	// an extra scale that is not fitted is stored as zero; pointer size is fixed
	always_comb begin
		wid_wr              = wid_in;
		wid_wr.zero         = 1'b0;
		wid_wr.pointer_size = 1'b0;
		if (wid_in.entry_extra_scale > pwic_pkg::EXTRA_SCALE_MAX) begin
			wid_wr.entry_extra_scale = 6'h00;
		end
		ctl_wr             = '0;
		ctl_wr.walk_enable = reg_wdata[31];
	end

	wire logic slot_ok = hit_pos ? pos_ok : (hit_wid ? wid_ok : 1'b1);
	wire logic wr_go   = reg_wr && hit_any && slot_ok;

	wire logic [31:0] wr_word = hit_pos ? 32'(pos_wr) :
	                            hit_wid ? 32'(wid_wr) :
	                            hit_ctl ? 32'(ctl_wr) : reg_wdata; // RULE20

	// ----------------------------------------------------------------
	// per-element register copies
	// ----------------------------------------------------------------
	pwic_state_t               st_q;
	pwic_state_t               st_d;
	logic [pwic_pkg::VPE_W-1:0] walk_vpe_q;
	pwic_pkg::pwic_cfg_t       reg_view;
	pwic_pkg::pwic_cfg_t       walk_view;

	// the walker port looks up the requesting element while still idle
	wire logic [pwic_pkg::VPE_W-1:0] cfg_vpe = (st_q == PWIC_IDLE) ? walk_vpe : walk_vpe_q;

	pwic_vpe_regs #(
		.RST_WORD (CFG_RST)
	) u_regs (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.ce        (ce),
		.wr_en     (wr_go),
		.wr_vpe    (reg_vpe),
		.wr_slot   (hit_slot),
		.wr_data   (wr_word),
		.rd_a_vpe  (reg_vpe),
		.rd_a_data (reg_view),
		.rd_b_vpe  (cfg_vpe),
		.rd_b_data (walk_view)
	); // RULE18

	// ----------------------------------------------------------------
	// register read: two cycles, absent or unmapped reads give zero
	// ----------------------------------------------------------------
	logic        rd_pend_q;
	logic        rd_hit_q;
	logic [1:0]  rd_slot_q;
	logic [31:0] reg_rdata_q;
	logic        reg_rvalid_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_pend_q <= 1'b0;
			rd_hit_q  <= 1'b0;
			rd_slot_q <= 2'h0;
		end else if (ce) begin
			rd_pend_q <= reg_rd;
			rd_hit_q  <= reg_rd && hit_any; // RULE1
			rd_slot_q <= hit_slot;
		end
	end

	wire logic [31:0] rd_word = reg_view[rd_slot_q*32 +: 32];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_q  <= 32'h0;
			reg_rvalid_q <= 1'b0;
		end else if (ce) begin
			reg_rdata_q  <= rd_hit_q ? rd_word : 32'h0;
			reg_rvalid_q <= rd_pend_q;
		end
	end

	// ----------------------------------------------------------------
	// index extraction for the current level
	// ----------------------------------------------------------------
	pwic_pkg::pwic_cfg_t cfg_q;
	logic [1:0]          lvl_q;
	logic [31:0]         cur_q;
	logic [31:0]         fault_addr_q;

	logic [5:0] lvl_pos;
	logic [5:0] lvl_wid;
	always_comb begin
		case (lvl_q)
			2'h0: begin
				lvl_pos = cfg_q.position.global_dir_position;
				lvl_wid = cfg_q.widths.global_dir_width;
			end
			2'h1: begin
				lvl_pos = cfg_q.position.upper_dir_position;
				lvl_wid = cfg_q.widths.upper_dir_width;
			end
			2'h2: begin
				lvl_pos = cfg_q.position.middle_dir_position;
				lvl_wid = cfg_q.widths.middle_dir_width;
			end
			default: begin
				lvl_pos = cfg_q.position.leaf_table_position;
				lvl_wid = cfg_q.widths.leaf_table_width;
			end
		endcase
	end

	wire logic        is_leaf   = (lvl_q == pwic_pkg::LVL_LEAF);
	// a zero-width directory is skipped without touching memory
	wire logic        lvl_skip  = !is_leaf && (lvl_wid == 6'h00); // RULE19
	wire logic [31:0] idx_mask  = ~(32'hffffffff << lvl_wid);
	wire logic [31:0] idx_raw   = (fault_addr_q >> lvl_pos) & idx_mask; // RULE5
	wire logic [5:0]  idx_scale = is_leaf ? (pwic_pkg::PTR_SCALE + cfg_q.widths.entry_extra_scale) // RULE15
	                                      : pwic_pkg::PTR_SCALE; // RULE14
	wire logic [31:0] lvl_addr  = cur_q + (idx_raw << idx_scale);

	// ----------------------------------------------------------------
	// loaded entry: drop software bits, rotate the low pair to the top
	// ----------------------------------------------------------------
	wire logic [5:0]  ent_shift = cfg_q.position.entry_shift - pwic_pkg::ENTRY_SHIFT_BIAS; // RULE9
	wire logic [31:0] ent_shr   = mem_rdata >> ent_shift; // RULE10
	wire logic [31:0] ent_rot   = {ent_shr[1:0], ent_shr[31:2]}; // RULE10
	// odd leaf positions lose one bit so the page is a power of four
	wire logic [5:0]  pg_shift  = {cfg_q.position.leaf_table_position[5:1], 1'b0}; // RULE8

	pwic_pkg::pwic_tlb_t ent_new;
	assign ent_new = '{read_inhibit:    ent_rot[31],
	                   execute_inhibit: ent_rot[30],
	                   entry_low:       ent_rot[29:0],
	                   page_shift:      pg_shift};

	// ----------------------------------------------------------------
	// walk sequencing
	// ----------------------------------------------------------------
	wire logic walk_ok  = walker_present_bit && walk_view.control.walk_enable;
	wire logic rd_done  = (st_q == PWIC_WAIT) && mem_rvalid;
	wire logic rd_fault = rd_done && mem_fault;

	always_comb begin
		case (st_q)
			PWIC_IDLE:  st_d = walk_req ? PWIC_CFG : PWIC_IDLE;
			PWIC_CFG:   st_d = walk_ok ? PWIC_LEVEL : PWIC_IDLE;
			PWIC_LEVEL: st_d = lvl_skip ? PWIC_LEVEL : PWIC_WAIT;
			PWIC_WAIT:  st_d = !rd_done ? PWIC_WAIT :
			                   (rd_fault || is_leaf) ? PWIC_IDLE : PWIC_LEVEL; // RULE2 RULE17
			default:    st_d = PWIC_IDLE;
		endcase
	end

	// request capture; faulting address held for the whole walk
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q         <= PWIC_IDLE;
			walk_vpe_q   <= '0;
			fault_addr_q <= 32'h0;
		end else if (ce) begin
			st_q <= st_d;
			if (st_q == PWIC_IDLE && walk_req) begin
				walk_vpe_q   <= walk_vpe;
				fault_addr_q <= walk_addr; // RULE21
			end
		end
	end

	// configuration snapshot and level pointer; the first table is the base
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_q <= CFG_RST;
			lvl_q <= 2'h0;
			cur_q <= 32'h0;
		end else if (ce) begin
			if (st_q == PWIC_CFG) begin
				cfg_q <= walk_view;
				lvl_q <= 2'h0;
				cur_q <= walk_view.base; // RULE16
			end else if (st_q == PWIC_LEVEL && lvl_skip) begin
				lvl_q <= lvl_q + 2'h1; // RULE19
			end else if (rd_done && !mem_fault && !is_leaf) begin
				lvl_q <= lvl_q + 2'h1; // RULE17
				cur_q <= mem_rdata;
			end
		end
	end

	// memory read request: a one-cycle pulse, address held until the answer
	logic        mem_req_q;
	logic [31:0] mem_addr_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mem_req_q  <= 1'b0;
			mem_addr_q <= 32'h0;
		end else if (ce) begin
			mem_req_q <= (st_q == PWIC_LEVEL) && !lvl_skip;
			if (st_q == PWIC_LEVEL && !lvl_skip) begin
				mem_addr_q <= lvl_addr;
			end
		end
	end

	// results: a fault never reaches the entry write strobe
	logic                tlb_we_q;
	pwic_pkg::pwic_tlb_t tlb_entry_q;
	logic                refill_exc_q;
	logic [31:0]         exc_addr_q;
	logic                walk_busy_q;
	wire  logic          cfg_refuse = (st_q == PWIC_CFG) && !walk_ok;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tlb_we_q     <= 1'b0;
			tlb_entry_q  <= '0;
			refill_exc_q <= 1'b0;
			exc_addr_q   <= 32'h0;
			walk_busy_q  <= 1'b0;
		end else if (ce) begin
			tlb_we_q     <= rd_done && !mem_fault && is_leaf; // RULE21
			refill_exc_q <= rd_fault || cfg_refuse; // RULE2
			walk_busy_q  <= (st_d != PWIC_IDLE);
			if (rd_done && !mem_fault && is_leaf) begin
				tlb_entry_q <= ent_new; // RULE10
			end
			if (rd_fault || cfg_refuse) begin
				exc_addr_q <= fault_addr_q; // RULE21
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata  = reg_rdata_q;
	assign reg_rvalid = reg_rvalid_q;
	assign walk_busy  = walk_busy_q;
	assign mem_req    = mem_req_q;
	assign mem_addr   = mem_addr_q;
	assign tlb_we     = tlb_we_q;
	assign tlb_entry  = tlb_entry_q;
	assign refill_exc = refill_exc_q;
	assign exc_addr   = exc_addr_q;

endmodule

// ### bench/pwic_walker_checker.sv
`timescale 1ns/100ps
module pwic_walker_checker (
	input wire logic                clk_sys,
	input wire logic                rst,
	input wire logic                ce,
	input wire logic                walker_present_bit,
	input wire logic                reg_rd,
	input wire logic [4:0]          reg_num,
	input wire logic [2:0]          reg_sel,
	input wire logic [31:0]         reg_rdata,
	input wire logic                reg_rvalid,
	input wire logic [31:0]         walk_addr,
	input wire logic                walk_busy,
	input wire logic                mem_req,
	input wire logic [31:0]         mem_addr,
	input wire logic                mem_rvalid,
	input wire logic                mem_fault,
	input wire logic                tlb_we,
	input wire pwic_pkg::pwic_tlb_t tlb_entry,
	input wire logic                refill_exc,
	input wire logic [31:0]         exc_addr
);
	// one clock domain, so one default clock and disable
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	rd_latency_a: assert property (ce && reg_rd |-> ##2 reg_rvalid)
		else $error("read answer late");
	rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
		else $error("read answer without read");
	high_zero_a: assert property (reg_rvalid && $past(reg_num, 2) == pwic_pkg::REG_NUM_WALK
		&& $past(reg_sel, 2) == pwic_pkg::SEL_POSITION |-> reg_rdata[31:30] == 2'h0)
		else $error("position top bits not zero");
	absent_zero_a: assert property (reg_rvalid && !$past(walker_present_bit, 2) |-> reg_rdata == 32'h0)
		else $error("absent register read not zero");
	fault_abort_a: assert property (mem_rvalid && mem_fault |=> refill_exc && !tlb_we)
		else $error("fault did not abort walk");
	exc_addr_a: assert property (refill_exc |-> !tlb_we && exc_addr == walk_addr)
		else $error("exception address wrong");
	busy_end_a: assert property ($fell(walk_busy) |-> tlb_we || refill_exc)
		else $error("walk ended without result");
	page_even_a: assert property (tlb_we |-> tlb_entry.page_shift[0] == 1'b0)
		else $error("page shift not power of four");
	mem_pulse_a: assert property (mem_req |=> !mem_req)
		else $error("read request not one pulse");
	addr_hold_a: assert property ($changed(mem_addr) |-> mem_req)
		else $error("read address moved without request");
endmodule

bind pwic_walker pwic_walker_checker u_chk (.*);

// ### bench/pwic_mem_model.sv
`timescale 1ns/100ps
module pwic_mem_model (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	input  wire logic [3:0]  delay,
	input  wire logic        fault_on,
	output logic             mem_rvalid,
	output logic             mem_fault,
	output logic [31:0]      mem_rdata
);
	logic [3:0]  cnt_q;
	logic        pend_q;
	logic [31:0] addr_q;

	// one read at a time; data is garbage outside the answer cycle
	always_ff @(posedge clk_sys) begin
		mem_rvalid <= 1'b0;
		mem_fault  <= 1'b0;
		mem_rdata  <= ~mem_rdata;
		if (rst) begin
			pend_q    <= 1'b0;
			mem_rdata <= 32'h0;
		end else if (mem_req) begin
			pend_q <= 1'b1;
			cnt_q  <= delay;
			addr_q <= mem_addr;
		end else if (pend_q && cnt_q == 4'h0) begin
			pend_q     <= 1'b0;
			mem_rvalid <= 1'b1;
			mem_fault  <= fault_on;
			if (!fault_on) mem_rdata <= addr_q + 32'h00010003;
		end else begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule

// ### bench/page_walk_index_config_tb_top.sv
`timescale 1ns/100ps
module page_walk_index_config_tb_top;
	logic clk_sys, rst, ce, pres, reg_wr, reg_rd, reg_vpe, walk_req, walk_vpe;
	logic [4:0] reg_num;
	logic [2:0] reg_sel;
	logic [31:0] reg_wdata, reg_rdata, walk_addr, mem_addr, mem_rdata, exc_addr;
	logic reg_rvalid, walk_busy, mem_req, mem_rvalid, mem_fault, tlb_we, refill_exc, fault_on;
	logic [3:0] delay;
	pwic_pkg::pwic_tlb_t tlb_entry;
	int bad_count, cmp_count, nreq;
	logic [31:0] maddr [4];

	pwic_walker i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .walker_present_bit(pres),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num), .reg_sel(reg_sel), .reg_vpe(reg_vpe),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .walk_req(walk_req),
		.walk_vpe(walk_vpe), .walk_addr(walk_addr), .walk_busy(walk_busy), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_fault(mem_fault), .mem_rdata(mem_rdata),
		.tlb_we(tlb_we), .tlb_entry(tlb_entry), .refill_exc(refill_exc), .exc_addr(exc_addr));
	pwic_mem_model i_mem (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
		.delay(delay), .fault_on(fault_on), .mem_rvalid(mem_rvalid), .mem_fault(mem_fault),
		.mem_rdata(mem_rdata));

	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [37:0] exp, input logic [37:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input logic [4:0] n, input logic [2:0] s, input logic v, input logic [31:0] d);
		@(posedge clk_sys) {reg_wr, reg_num, reg_sel, reg_vpe, reg_wdata} <= {1'b1, n, s, v, d};
		@(posedge clk_sys) reg_wr <= 1'b0;
	endtask

	// answer arrives two edges after the edge that drives the read
	task automatic rd(input logic [4:0] n, input logic [2:0] s, input logic v, input logic [31:0] e,
		input string what);
		@(posedge clk_sys) {reg_rd, reg_num, reg_sel, reg_vpe} <= {1'b1, n, s, v};
		@(posedge clk_sys) reg_rd <= 1'b0;
		@(posedge clk_sys);
		#1 chk({what, " valid"}, 1, reg_rvalid);
		chk(what, e, reg_rdata);
	endtask

	// bounded wait for the walk result, logging every read address
	task automatic walk(input logic [31:0] a);
		nreq = 0;
		@(posedge clk_sys) {walk_req, walk_addr} <= {1'b1, a};
		@(posedge clk_sys) walk_req <= 1'b0;
		for (int i = 0; i < 80; i++) begin
			@(posedge clk_sys);
			#1;
			if (mem_req === 1'b1 && nreq < 4) begin
				maddr[nreq] = mem_addr;
				nreq++;
			end
			if (tlb_we === 1'b1 || refill_exc === 1'b1) return;
		end
		bad_count++;
		$display("[FAIL] walk result never came");
		wrap_up();
	endtask

	localparam logic [4:0] W = pwic_pkg::REG_NUM_WALK;
	localparam logic [31:0] POS = {2'h0, 6'h14, 6'h0c, 6'h0c, 6'h0d, 6'h04};

	task automatic t_reset;
		rd(W, pwic_pkg::SEL_POSITION, 0, {2'h0, {4{pwic_pkg::POS_RST_NEWEST}}, pwic_pkg::ENTRY_SHIFT_RST},
			"position reset");
		rd(W, pwic_pkg::SEL_BASE, 1, 32'h0, "base reset");
		rd(W, pwic_pkg::SEL_WIDTHS, 0, 32'h0, "widths reset");
		rd(pwic_pkg::REG_NUM_CTRL, pwic_pkg::SEL_CONTROL, 0, 32'h0, "control reset");
		rd(5'h07, 3'h0, 0, 32'h0, "unmapped read");
		$display("reset test done");
	endtask

	task automatic t_fields;
		logic [31:0] cur;
		wr(W, pwic_pkg::SEL_POSITION, 0, POS | 32'hc0000000);
		rd(W, pwic_pkg::SEL_POSITION, 0, POS, "position write");
		wr(W, pwic_pkg::SEL_POSITION, 0, POS & ~32'h00004000);
		rd(W, pwic_pkg::SEL_POSITION, 0, POS, "low position dropped");
		cur = POS;
		// shift 0 and 1 go only to the newest release, which refuses them
		for (int v = 0; v < 10; v++) begin
			wr(W, pwic_pkg::SEL_POSITION, 0, {POS[31:6], 6'(v)});
			if (v >= 2 && v <= 8) cur = {POS[31:6], 6'(v)};
			rd(W, pwic_pkg::SEL_POSITION, 0, cur, "entry shift probe");
		end
		wr(W, pwic_pkg::SEL_POSITION, 0, POS);
		wr(W, pwic_pkg::SEL_BASE, 1, 32'hdead0000);
		rd(W, pwic_pkg::SEL_BASE, 0, 32'h0, "other element base");
		rd(W, pwic_pkg::SEL_BASE, 1, 32'hdead0000, "element base");
		$display("field test done");
	endtask

	task automatic t_walk;
		logic [31:0] a, l, d;
		a = 32'h01234567;
		wr(W, pwic_pkg::SEL_BASE, 0, 32'h00001000);
		wr(W, pwic_pkg::SEL_WIDTHS, 0, {2'h0, 6'h04, 6'h00, 6'h00, 6'h04, 6'h01});
		wr(pwic_pkg::REG_NUM_CTRL, pwic_pkg::SEL_CONTROL, 0, 32'h80000000);
		delay <= 4'h3;
		walk(a);
		l = 32'h00010003 + 32'h1000 + (((a >> 20) & 32'hf) << 2) + (((a >> 13) & 32'hf) << 3);
		d = (l + 32'h00010003) >> 2;
		chk("read count", 2, nreq);
		chk("dir address", 32'h1000 + (((a >> 20) & 32'hf) << 2), maddr[0]);
		chk("leaf address", l, maddr[1]);
		chk("tlb write", 1, tlb_we);
		chk("tlb entry", {d[1], d[0], d[31:2], 6'h0c}, tlb_entry);
		fault_on <= 1'b1;
		delay <= 4'h0;
		walk(a ^ 32'h00f00000);
		chk("fault result", 2'b01, {tlb_we, refill_exc});
		chk("fault reads", 1, nreq);
		chk("fault address", a ^ 32'h00f00000, exc_addr);
		fault_on <= 1'b0;
		$display("walk test done");
	endtask

	task automatic t_absent;
		pres <= 1'b0;
		rd(W, pwic_pkg::SEL_POSITION, 0, 32'h0, "absent position");
		walk(32'h00400000);
		chk("absent walk", 3'b001, {nreq[0], tlb_we, refill_exc});
		chk("absent reads", 0, nreq);
		pres <= 1'b1;
		$display("absent test done");
	endtask

	initial begin
		{rst, ce, pres, reg_wr, reg_rd, reg_vpe, walk_req, walk_vpe, fault_on} = 9'b111000000;
		{reg_num, reg_sel, reg_wdata, walk_addr, delay} = '0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_fields();
		t_walk();
		t_absent();
		wrap_up();
	end
endmodule
